// >>> hdl/tte_defines.vh
// constants for the trap, bit test and exclusive-or execution block
`ifndef TTE_DEFINES_VH
`define TTE_DEFINES_VH
`define TTE_OP_NOP 5'h00
`define TTE_OP_TRAP 5'h01
`define TTE_OP_BITTEST 5'h02
`define TTE_OP_BITTEST_3OP 5'h03
`define TTE_OP_XOR 5'h04
`define TTE_OP_XOR_3OP 5'h05
`define TTE_OP_ADDC_3OP 5'h06
`define TTE_OP_ADDI_3OP 5'h07
`define TTE_OP_ADDF_3OP 5'h08
`define TTE_OP_AND_3OP 5'h09
`define TTE_OP_ANDN_3OP 5'h0a
`define TTE_OP_ASH_3OP 5'h0b
`define TTE_OP_LSH_3OP 5'h0c
`define TTE_OP_CMPI_3OP 5'h0d
`define TTE_OP_CMPF_3OP 5'h0e
`define TTE_OP_MPYI_3OP 5'h0f
`define TTE_OP_MPYF_3OP 5'h10
`define TTE_OP_OR_3OP 5'h11
`define TTE_OP_SUBB_3OP 5'h12
`define TTE_OP_SUBI_3OP 5'h13
`define TTE_OP_SUBF_3OP 5'h14
`define TTE_SR_C 0
`define TTE_SR_V 1
`define TTE_SR_Z 2
`define TTE_SR_N 3
`define TTE_SR_IE 13
`define TTE_SR_RESET 32'h00000000
`define TTE_SP_RESET 24'h000000
`define TTE_VEC_BASE 24'h000020
`endif

// >>> hdl/tte_exec.v
// execution stage for trap, bit test, exclusive-or and three-operand forms
// Behaviour
// RULE1: taken trap pushes next PC at ++SP, loads vector N, leaves ints off.
// RULE2: the trap selector is a five-bit immediate choosing one of 32 vectors.
// RULE3: a trap clears interrupt enable, restoring it if the condition fails.
// RULE4: two-operand bit test ANDs source and destination, flags only.
// RULE5: three-operand bit test ANDs both sources, flags only.
// RULE6: two-operand exclusive OR writes source XOR destination back.
// RULE7: three-operand exclusive OR writes source one XOR source two to dst.
// RULE8: both three-operand sources are fetched in the single execute cycle.
// RULE9: each source is memory or register; the destination is a register.
// RULE10: a two-operand form has one source or count plus one destination.
// RULE11: three-operand forms exist for the listed arithmetic and logic ops.
// RULE12: eight auxiliary and eight extended-precision registers exist.
// RULE13: branch target immediates are 24 bits wide.
// RULE14: sources are read first, destinations written at the cycle end.
// RULE15: test and exclusive OR set Z and N, clear overflow, keep carry.
`timescale 1ns/10ps
`include "tte_defines.vh"
module tte_exec #(
    parameter DATA_W = 32,
    parameter ADDR_W = 24
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // decoded instruction
    input wire issue,
    input wire [4:0] opcode,
    input wire [4:0] trapVector,
    input wire condTrue,
    input wire src1IsMem,
    input wire [3:0] src1Reg,
    input wire [DATA_W-1:0] src1Mem,
    input wire src2IsMem,
    input wire [3:0] src2Reg,
    input wire [DATA_W-1:0] src2Mem,
    input wire [3:0] dstReg,
    input wire [ADDR_W-1:0] nextPc,
    // trap vector table read
    input wire [ADDR_W-1:0] vectorData,
    output wire [ADDR_W-1:0] vectorAddr,
    // program flow and stack push
    output reg pcLoad,
    output reg [ADDR_W-1:0] pcValue,
    output reg stackWrite,
    output reg [ADDR_W-1:0] stackAddr,
    output reg [ADDR_W-1:0] stackData,
    // architectural state
    output reg [DATA_W-1:0] statusReg,
    output reg [ADDR_W-1:0] stackPointer,
    output reg illegalOp,
    // register file observe port
    input wire [3:0] peekSel,
    output wire [DATA_W-1:0] peekData
);
    reg rstMeta;
    reg rstSync;
    // index 0..7 extended precision, 8..15 auxiliary
    localparam REG_COUNT = 16;
    reg [DATA_W-1:0] regFile [0:REG_COUNT-1]; // RULE12
    reg [DATA_W-1:0] next_result;
    reg next_write;
    reg next_flags;
    reg next_logic;
    reg [DATA_W:0] wide;
    reg [2*DATA_W-1:0] prod;
    integer i;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // operand fetch: each source from memory or register, same cycle
    function [DATA_W-1:0] pick;
        input isMem;
        input [DATA_W-1:0] memVal;
        input [DATA_W-1:0] regVal;
        begin
            pick = isMem ? memVal : regVal; // RULE9
        end
    endfunction

    // shift by signed count; arithmetic keeps sign on right shift
    function [DATA_W-1:0] shiftBy;
        input [DATA_W-1:0] val;
        input [DATA_W-1:0] cnt;
        input arith;
        reg [6:0] amt;
        begin
            amt = cnt[6:0];
            if (!cnt[6]) begin
                shiftBy = val << amt[5:0];
            end else if (arith) begin
                shiftBy = $signed(val) >>> (~amt[5:0] + 6'h01);
            end else begin
                shiftBy = val >> (~amt[5:0] + 6'h01);
            end
        end
    endfunction

    wire [DATA_W-1:0] dstVal = regFile[dstReg];
    // both sources sampled before this cycle's writes
    wire [DATA_W-1:0] opA = pick(src1IsMem, src1Mem, regFile[src1Reg]); // RULE8
    wire [DATA_W-1:0] opB = pick(src2IsMem, src2Mem, regFile[src2Reg]); // RULE14
    wire carryIn = statusReg[`TTE_SR_C];
    wire isTrap = issue && (opcode == `TTE_OP_TRAP);
    wire wrEn = issue && next_write; // RULE9

    wire [ADDR_W-1:0] vecOffset = {{(ADDR_W-5){1'b0}}, trapVector};
    assign vectorAddr = `TTE_VEC_BASE + vecOffset; // RULE2
    assign peekData = regFile[peekSel];

    // floating forms are passed through as raw integer arithmetic here;
    // a real float unit would slot in at these case items
    always @* begin
        next_result = {DATA_W{1'b0}};
        next_write = 1'b0;
        next_flags = 1'b0;
        next_logic = 1'b0;
        wide = {(DATA_W+1){1'b0}};
        prod = {(2*DATA_W){1'b0}};
        case (opcode)
            `TTE_OP_BITTEST: begin
                next_result = dstVal & opA; // RULE4
                next_flags = 1'b1;
                next_logic = 1'b1;
            end
            `TTE_OP_BITTEST_3OP: begin
                next_result = opA & opB; // RULE5
                next_flags = 1'b1;
                next_logic = 1'b1;
            end
            `TTE_OP_XOR: begin
                next_result = dstVal ^ opA; // RULE6 RULE10
                next_write = 1'b1;
                next_flags = 1'b1;
                next_logic = 1'b1;
            end
            `TTE_OP_XOR_3OP: begin
                next_result = opA ^ opB; // RULE7
                next_write = 1'b1;
                next_flags = 1'b1;
                next_logic = 1'b1;
            end
            `TTE_OP_ADDC_3OP: begin
                wide = {1'b0, opA} + {1'b0, opB} + {{DATA_W{1'b0}}, carryIn};
                next_result = wide[DATA_W-1:0]; // RULE11
                next_write = 1'b1;
                next_flags = 1'b1;
            end
            `TTE_OP_ADDI_3OP, `TTE_OP_ADDF_3OP: begin
                wide = {1'b0, opA} + {1'b0, opB};
                next_result = wide[DATA_W-1:0];
                next_write = 1'b1;
                next_flags = 1'b1;
            end
            `TTE_OP_AND_3OP: begin
                next_result = opA & opB;
                next_write = 1'b1;
                next_flags = 1'b1;
                next_logic = 1'b1;
            end
            `TTE_OP_ANDN_3OP: begin
                next_result = opB & ~opA;
                next_write = 1'b1;
                next_flags = 1'b1;
                next_logic = 1'b1;
            end
            `TTE_OP_OR_3OP: begin
                next_result = opA | opB;
                next_write = 1'b1;
                next_flags = 1'b1;
                next_logic = 1'b1;
            end
            `TTE_OP_ASH_3OP, `TTE_OP_LSH_3OP: begin
                next_result = shiftBy(opB, opA, opcode == `TTE_OP_ASH_3OP);
                next_write = 1'b1;
                next_flags = 1'b1;
                next_logic = 1'b1;
            end
            `TTE_OP_CMPI_3OP, `TTE_OP_CMPF_3OP: begin
                wide = {1'b0, opA} - {1'b0, opB};
                next_result = wide[DATA_W-1:0];
                next_flags = 1'b1;
            end
            `TTE_OP_MPYI_3OP, `TTE_OP_MPYF_3OP: begin
                prod = opA * opB;
                next_result = prod[DATA_W-1:0];
                next_write = 1'b1;
                next_flags = 1'b1;
            end
            `TTE_OP_SUBB_3OP: begin
                wide = {1'b0, opA} - {1'b0, opB} - {{DATA_W{1'b0}}, carryIn};
                next_result = wide[DATA_W-1:0];
                next_write = 1'b1;
                next_flags = 1'b1;
            end
            `TTE_OP_SUBI_3OP, `TTE_OP_SUBF_3OP: begin
                wide = {1'b0, opA} - {1'b0, opB};
                next_result = wide[DATA_W-1:0];
                next_write = 1'b1;
                next_flags = 1'b1;
            end
            default: begin
                next_result = {DATA_W{1'b0}};
            end
        endcase
    end

    // register file: destination always a register, written at cycle end
    always @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            for (i = 0; i < REG_COUNT; i = i + 1) begin
                regFile[i] <= {DATA_W{1'b0}};
            end
        end else if (wrEn) begin
            regFile[dstReg] <= next_result; // RULE9 RULE14
        end
    end

    // true for every code that the decoder above handles
    function isKnown;
        input [4:0] op;
        begin
            isKnown = (op <= `TTE_OP_SUBF_3OP);
        end
    endfunction

    // a trap drops the interrupt enable and a failed condition puts it
    // back, so the net effect is: cleared only when the trap is taken;
    // the restore term keeps the prior bit rather than forcing one
    wire ieAfterTrap = condTrue ? 1'b0 : statusReg[`TTE_SR_IE]; // RULE3
    wire takeTrap = isTrap && condTrue; // RULE1
    wire [ADDR_W-1:0] spInc = stackPointer + {{(ADDR_W-1){1'b0}}, 1'b1};
    wire doFlags = issue && !isTrap && next_flags;
    wire badOp = issue && !isKnown(opcode);

    // status register: flags from the datapath, enable from the trap
    always @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            statusReg <= `TTE_SR_RESET;
        end else if (isTrap) begin
            statusReg[`TTE_SR_IE] <= ieAfterTrap; // RULE1 RULE3
        end else if (doFlags) begin
            statusReg[`TTE_SR_Z] <= (next_result == {DATA_W{1'b0}});
            statusReg[`TTE_SR_N] <= next_result[DATA_W-1];
            if (next_logic) begin
                statusReg[`TTE_SR_V] <= 1'b0; // RULE15
            end else begin
                statusReg[`TTE_SR_C] <= wide[DATA_W];
            end
        end
    end

    // stack push at the pre-incremented pointer; no overflow check,
    // the pointer simply wraps at the top of the address space
    always @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            stackPointer <= `TTE_SP_RESET;
            stackWrite <= 1'b0;
            stackAddr <= {ADDR_W{1'b0}};
            stackData <= {ADDR_W{1'b0}};
        end else begin
            stackWrite <= takeTrap; // RULE1
            if (takeTrap) begin
                stackPointer <= spInc;
                stackAddr <= spInc;
                stackData <= nextPc; // RULE13
            end
        end
    end

    // program counter load from the vector table entry
    always @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            pcLoad <= 1'b0;
            pcValue <= {ADDR_W{1'b0}};
        end else begin
            pcLoad <= takeTrap; // RULE1
            if (takeTrap) begin
                pcValue <= vectorData; // RULE2
            end
        end
    end

    // unknown codes change nothing and raise a one-cycle flag
    always @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            illegalOp <= 1'b0;
        end else begin
            illegalOp <= badOp;
        end
    end
endmodule // tte_exec

// >>> verif/tte_exec_props.sv
// concurrent checks on the execution block ports
`timescale 1ns/10ps
`include "tte_defines.vh"
module tte_exec_props #(
    parameter DATA_W = 32,
    parameter ADDR_W = 24
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // decoded instruction
    input wire issue,
    input wire [4:0] opcode,
    input wire [4:0] trapVector,
    input wire condTrue,
    input wire src1IsMem,
    input wire [DATA_W-1:0] src1Mem,
    input wire src2IsMem,
    input wire [DATA_W-1:0] src2Mem,
    input wire [ADDR_W-1:0] nextPc,
    input wire [ADDR_W-1:0] vectorData,
    input wire [ADDR_W-1:0] vectorAddr,
    // results
    input wire pcLoad,
    input wire [ADDR_W-1:0] pcValue,
    input wire stackWrite,
    input wire [ADDR_W-1:0] stackAddr,
    input wire [ADDR_W-1:0] stackData,
    input wire [DATA_W-1:0] statusReg,
    input wire [ADDR_W-1:0] stackPointer
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire isTrap = issue && opcode == `TTE_OP_TRAP;
    wire bothMem = issue && src1IsMem && src2IsMem;
    wire logicOp = issue && (opcode == `TTE_OP_BITTEST ||
        opcode == `TTE_OP_BITTEST_3OP || opcode == `TTE_OP_XOR ||
        opcode == `TTE_OP_XOR_3OP);
    sequence trapTaken;
        isTrap && condTrue;
    endsequence
    sequence trapSkipped;
        isTrap && !condTrue;
    endsequence
    a_trap_push: assert property (trapTaken |=> stackWrite &&
        stackData == $past(nextPc) && stackAddr == $past(stackPointer) + 1)
        else $error("trap push wrong");
    a_trap_jump: assert property (trapTaken |=> pcLoad &&
        pcValue == $past(vectorData)) else $error("trap jump wrong");
    a_trap_ie_off: assert property (trapTaken |=>
        !statusReg[`TTE_SR_IE]) else $error("interrupts left on");
    a_stack_inc: assert property (trapTaken |=>
        stackPointer == $past(stackPointer) + 1) else $error("sp wrong");
    a_vector_sel: assert property (isTrap |->
        vectorAddr == `TTE_VEC_BASE + trapVector) else $error("bad vector");
    a_trap_skip: assert property (trapSkipped |=> !pcLoad &&
        !stackWrite && $stable(statusReg)) else $error("false trap acted");
    a_logic_flags: assert property (logicOp |=>
        !statusReg[`TTE_SR_V] && statusReg[`TTE_SR_C] ==
        $past(statusReg[`TTE_SR_C])) else $error("logic flags wrong");
    a_test_zero: assert property (
        bothMem && opcode == `TTE_OP_BITTEST_3OP |=>
        statusReg[`TTE_SR_Z] == (($past(src1Mem) & $past(src2Mem)) == 0))
        else $error("bit test zero wrong");
    a_xor_sign: assert property (
        bothMem && opcode == `TTE_OP_XOR_3OP |=>
        statusReg[`TTE_SR_N] == ($past(src1Mem[DATA_W-1]) ^
        $past(src2Mem[DATA_W-1]))) else $error("xor sign wrong");
endmodule // tte_exec_props
bind tte_exec tte_exec_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_props (.*);

// >>> verif/testbench.sv
// self-checking bench for the execution block
`timescale 1ns/10ps
`include "tte_defines.vh"
module testbench;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg issue = 1'b0;
    reg [4:0] opcode = 5'h00;
    reg [4:0] trapVector = 5'h00;
    reg condTrue = 1'b0;
    reg src1IsMem = 1'b0;
    reg src2IsMem = 1'b0;
    reg [3:0] src1Reg = 4'h0;
    reg [3:0] src2Reg = 4'h0;
    reg [3:0] dstReg = 4'h0;
    reg [3:0] peekSel = 4'h0;
    reg [31:0] src1Mem = 32'h0;
    reg [31:0] src2Mem = 32'h0;
    reg [23:0] nextPc = 24'h0;
    reg [23:0] vectorData = 24'h0;
    wire [23:0] vectorAddr, pcValue, stackAddr, stackData, stackPointer;
    wire pcLoad, stackWrite, illegalOp;
    wire [31:0] statusReg, peekData;
    integer numErrors = 0;
    integer nTests = 0;
    tte_exec DUT (.*);
    always #5 clk = ~clk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            nTests = nTests + 1;
            if (got !== exp) begin
                numErrors = numErrors + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // issue stays high so back-to-back calls never toggle it twice
    task run(input [4:0] op, input m1, input [3:0] r1, input [31:0] v1,
        input m2, input [3:0] r2, input [31:0] v2, input [3:0] d);
        begin
            opcode = op;
            src1IsMem = m1;
            src1Reg = r1;
            src1Mem = v1;
            src2IsMem = m2;
            src2Reg = r2;
            src2Mem = v2;
            dstReg = d;
            issue = 1'b1;
            @(posedge clk);
            #1;
        end
    endtask
    task peek(input [3:0] r, input [31:0] exp);
        begin
            issue = 1'b0;
            peekSel = r;
            @(posedge clk);
            #1 chk(peekData, exp);
        end
    endtask
    task sXor;
        begin
            run(`TTE_OP_XOR_3OP, 1, 0, 32'hf0f01234, 1, 0, 0, 4'h0);
            run(`TTE_OP_XOR_3OP, 1, 0, 32'h0ff04321, 1, 0, 0, 4'hb);
            run(`TTE_OP_XOR_3OP, 0, 4'h0, 0, 0, 4'hb, 0, 4'h5);
            chk(statusReg[3:1], 3'b100);
            peek(4'hb, 32'h0ff04321);
            peek(4'h5, 32'hff005115);
            run(`TTE_OP_XOR, 1, 0, 32'hff005115, 0, 0, 0, 4'h5);
            chk(statusReg[3:1], 3'b010);
            peek(4'h5, 32'h0);
        end
    endtask
    task sTest;
        begin
            run(`TTE_OP_XOR_3OP, 1, 0, 32'h800000ff, 1, 0, 0, 4'h2);
            run(`TTE_OP_BITTEST, 1, 0, 32'h00000f00, 0, 0, 0, 4'h2);
            chk(statusReg[3:1], 3'b010);
            run(`TTE_OP_BITTEST_3OP, 0, 4'h2, 0, 1, 0, 32'h80000001, 4'h0);
            chk(statusReg[3:1], 3'b100);
            peek(4'h2, 32'h800000ff);
            peek(4'h0, 32'hf0f01234);
        end
    endtask
    task trap(input [4:0] n, input c, input [23:0] sp);
        begin
            trapVector = n;
            condTrue = c;
            nextPc = 24'h001200 + n;
            vectorData = 24'h00a000 + n;
            run(`TTE_OP_TRAP, 0, 0, 0, 0, 0, 0, 0);
            chk(vectorAddr, `TTE_VEC_BASE + n);
            chk({pcLoad, stackWrite}, {c, c});
            chk(stackPointer, sp);
            chk(statusReg[`TTE_SR_IE], 0);
            if (c) begin
                chk(pcValue, vectorData);
                chk(stackAddr, sp);
                chk(stackData, nextPc);
            end
        end
    endtask
    task sOps;
        integer i;
        begin
            for (i = 0; i < 32; i = i + 1) begin
                run(i[4:0], 1, 0, 32'h3, 1, 0, 32'h1, 4'h7);
                chk(illegalOp, i > 20);
            end
        end
    endtask
    task reportAndStop;
        begin
            if (numErrors == 0 && nTests > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        numErrors = numErrors + 1;
        reportAndStop;
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        sXor;
        sTest;
        trap(5'h1f, 1'b1, 24'h000001);
        trap(5'h00, 1'b1, 24'h000002);
        trap(5'h05, 1'b0, 24'h000002);
        sOps;
        reportAndStop;
    end
endmodule // testbench
